/* File: design/bsd_pkg.sv */
// package: constants and types for the branch and skip decision unit
package bsd_pkg;

	localparam int PC_W        = 16;
	localparam int OFS_W       = 7;
	localparam int STEP_SEQ    = 1;
	localparam int STEP_SKIP1  = 2;
	localparam int STEP_SKIP2  = 3;
	localparam int CYC_ONE     = 1;
	localparam int CYC_TWO     = 2;
	localparam int CYC_THREE   = 3;
	localparam int FLG_C       = 0;
	localparam int FLG_Z       = 1;
	localparam int FLG_N       = 2;
	localparam int FLG_V       = 3;
	localparam int FLG_S       = 4;
	localparam int FLG_H       = 5;
	localparam int FLG_T       = 6;
	localparam int FLG_I       = 7;
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [PC_W-1:0] PC_RST = 16'h0000;

	typedef enum logic [3:0]
	{
		OP_NONE,
		OP_COMPARE_IMM,
		OP_SKIP_REG_BIT_CLEAR,
		OP_SKIP_IO_BIT_SET,
		OP_SKIP_IO_BIT_CLEAR,
		OP_BRANCH_FLAG_SET,
		OP_BRANCH_FLAG_CLEAR,
		OP_BRANCH_CARRY_CLEAR,
		OP_BRANCH_UNSIGNED_GE,
		OP_BRANCH_SIGNED_GE,
		OP_BRANCH_SIGNED_LT,
		OP_BRANCH_HALFCARRY_SET,
		OP_BRANCH_TRANSFER_BIT_SET,
		OP_BRANCH_OVERFLOW_SET
	} bsd_op_t;

	typedef struct packed
	{
		bsd_op_t           op;
		logic [2:0]        sel;
		logic [OFS_W-1:0]  offset;
		logic [7:0]        reg_val;
		logic [7:0]        imm;
		logic [7:0]        io_val;
		logic              next_two_words;
	} bsd_req_t;

	typedef struct packed
	{
		logic [PC_W-1:0]   pc;
		logic              taken;
		logic [1:0]        cycles;
	} bsd_res_t;

endpackage

/* File: design/bsd_cmp.sv */
// module: compare-with-immediate flag computation
`timescale 1ns/10ps
module bsd_cmp
(
	input  wire logic [7:0] rd_i,
	input  wire logic [7:0] k_i,
	input  wire logic [7:0] flags_i,
	output logic      [7:0] flags_o
);
	import bsd_pkg::*;

	logic [7:0] diff;
	logic       carry;
	logic       half;
	logic       ovf;

	// subtraction only; result never stored [RQ13]
	always_comb
	begin
		diff  = rd_i - k_i;
		carry = (~rd_i[7] & k_i[7]) | (k_i[7] & diff[7]) | (diff[7] & ~rd_i[7]);
		half  = (~rd_i[3] & k_i[3]) | (k_i[3] & diff[3]) | (diff[3] & ~rd_i[3]);
		ovf   = (rd_i[7] & ~k_i[7] & ~diff[7]) | (~rd_i[7] & k_i[7] & diff[7]);
		flags_o        = flags_i;
		flags_o[FLG_C] = carry;
		flags_o[FLG_Z] = (diff == 8'h00);
		flags_o[FLG_N] = diff[7];
		flags_o[FLG_V] = ovf;
		flags_o[FLG_S] = diff[7] ^ ovf;
		flags_o[FLG_H] = half;
	end

endmodule

/* File: design/bsd_unit.sv */
// module: branch and skip decision unit of the core
// How it works
// [RQ1] skip next instruction when chosen general register bit is zero; 1/2/3 cycles
// [RQ2] skip next instruction when chosen I/O register bit reads one
// [RQ3] skip next instruction when chosen I/O register bit reads zero
// [RQ4] branch to pc+offset+1 when indexed flag is one; 1 or 2 cycles
// [RQ5] branch to pc+offset+1 when indexed flag is zero
// [RQ6] carry-clear branch taken on carry zero, not taken on carry set
// [RQ7] unsigned same-or-higher branch taken exactly when carry clear
// [RQ8] signed greater-or-equal branch taken when negative xor overflow is zero
// [RQ9] signed less-than branch taken when negative xor overflow is one
// [RQ10] branch when half-carry flag is one
// [RQ11] branch when transfer bit is one, fall through otherwise
// [RQ12] branch when overflow flag is one, continue sequentially otherwise
// [RQ13] compare-immediate sets Z N V C H in one cycle, result discarded
// [RQ14] offset is signed word count; skip adds two or three words
`timescale 1ns/10ps
module bsd_unit
(
	input  wire logic              clk_sys_i,
	input  wire logic              rst_i,
	input  wire logic              req_valid_i,
	input  wire bsd_pkg::bsd_req_t req_i,
	input  wire logic [15:0]       pc_i,
	input  wire logic              flags_load_i,
	input  wire logic [7:0]        flags_i,
	output logic                   res_valid_o,
	output bsd_pkg::bsd_res_t      res_o,
	output logic [7:0]             status_flags_o
);
	import bsd_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// state

	bsd_res_t   res_reg;
	bsd_res_t   res_next;
	logic       valid_reg;
	logic       valid_next;
	logic [7:0] status_flags_reg;
	logic [7:0] status_flags_next;
	logic [7:0] cmp_flags;

	logic       cond;
	logic       is_skip;
	logic       is_branch;
	logic [PC_W-1:0] ofs_ext;
	logic [PC_W-1:0] skip_step;

	////////////////////////////////////////////////////////////////////////////////
	// compare

	bsd_cmp u_cmp
	(
		.rd_i    (req_i.reg_val),
		.k_i     (req_i.imm),
		.flags_i (status_flags_reg),
		.flags_o (cmp_flags)
	);

	////////////////////////////////////////////////////////////////////////////////
	// decision

	always_comb
	begin
		cond      = 1'b0;
		is_skip   = 1'b0;
		is_branch = 1'b0;
		unique case (req_i.op)
			OP_NONE,
			OP_COMPARE_IMM:
			begin
				cond = 1'b0;
			end
			OP_SKIP_REG_BIT_CLEAR:
			begin
				is_skip = 1'b1;
				cond    = ~req_i.reg_val[req_i.sel]; // [RQ1]
			end
			OP_SKIP_IO_BIT_SET:
			begin
				is_skip = 1'b1;
				cond    = req_i.io_val[req_i.sel]; // [RQ2]
			end
			OP_SKIP_IO_BIT_CLEAR:
			begin
				is_skip = 1'b1;
				cond    = ~req_i.io_val[req_i.sel]; // [RQ3]
			end
			OP_BRANCH_FLAG_SET:
			begin
				is_branch = 1'b1;
				cond      = status_flags_reg[req_i.sel]; // [RQ4]
			end
			OP_BRANCH_FLAG_CLEAR:
			begin
				is_branch = 1'b1;
				cond      = ~status_flags_reg[req_i.sel]; // [RQ5]
			end
			OP_BRANCH_CARRY_CLEAR:
			begin
				is_branch = 1'b1;
				cond      = ~status_flags_reg[FLG_C]; // [RQ6]
			end
			OP_BRANCH_UNSIGNED_GE:
			begin
				is_branch = 1'b1;
				cond      = ~status_flags_reg[FLG_C]; // [RQ7]
			end
			OP_BRANCH_SIGNED_GE:
			begin
				is_branch = 1'b1;
				cond      = ~(status_flags_reg[FLG_N] ^ status_flags_reg[FLG_V]); // [RQ8]
			end
			OP_BRANCH_SIGNED_LT:
			begin
				is_branch = 1'b1;
				cond      = status_flags_reg[FLG_N] ^ status_flags_reg[FLG_V]; // [RQ9]
			end
			OP_BRANCH_HALFCARRY_SET:
			begin
				is_branch = 1'b1;
				cond      = status_flags_reg[FLG_H]; // [RQ10]
			end
			OP_BRANCH_TRANSFER_BIT_SET:
			begin
				is_branch = 1'b1;
				cond      = status_flags_reg[FLG_T]; // [RQ11]
			end
			OP_BRANCH_OVERFLOW_SET:
			begin
				is_branch = 1'b1;
				cond      = status_flags_reg[FLG_V]; // [RQ12]
			end
			default:
			begin
				cond = 1'b0;
			end
		endcase
	end

	// sign extension keeps backward branches correct across the pc width [RQ14]
	assign ofs_ext   = {{(PC_W-OFS_W){req_i.offset[OFS_W-1]}}, req_i.offset};
	assign skip_step = req_i.next_two_words ? PC_W'(STEP_SKIP2) : PC_W'(STEP_SKIP1); // [RQ14]

	////////////////////////////////////////////////////////////////////////////////
	// result

	// cycles only reports what the core spends; this unit answers in one
	always_comb
	begin
		res_next   = res_reg;
		valid_next = 1'b0;
		if (req_valid_i)
		begin
			valid_next      = 1'b1;
			res_next.taken  = cond;
			res_next.pc     = pc_i + PC_W'(STEP_SEQ);
			res_next.cycles = 2'(CYC_ONE);
			if (is_skip && cond)
			begin
				res_next.pc     = pc_i + skip_step; // [RQ1] [RQ2] [RQ3]
				res_next.cycles = req_i.next_two_words ? 2'(CYC_THREE) : 2'(CYC_TWO); // [RQ1]
			end
			else if (is_branch && cond)
			begin
				res_next.pc     = pc_i + ofs_ext + PC_W'(STEP_SEQ); // [RQ4] [RQ5]
				res_next.cycles = 2'(CYC_TWO); // [RQ4]
			end
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			res_reg   <= '{pc: PC_RST, taken: 1'b0, cycles: 2'h0};
			valid_reg <= 1'b0;
		end
		else
		begin
			res_reg   <= res_next;
			valid_reg <= valid_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// status flags

	// compare beats a same-cycle load so its flags are never lost
	always_comb
	begin
		status_flags_next = status_flags_reg;
		if (req_valid_i && (req_i.op == OP_COMPARE_IMM))
		begin
			status_flags_next = cmp_flags; // [RQ13]
		end
		else if (flags_load_i)
		begin
			status_flags_next = flags_i;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			status_flags_reg <= FLAGS_RST;
		end
		else
		begin
			status_flags_reg <= status_flags_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// elaboration checks

	// offset must be narrower than the pc or sign extension breaks
	if (OFS_W >= PC_W)
	begin : g_bad_width
		$error("offset not narrower than pc");
	end

	assign res_valid_o    = valid_reg;
	assign res_o          = res_reg;
	assign status_flags_o = status_flags_reg;

endmodule

/* File: tb/bsd_ref_pkg.sv */
// package: reference decisions shared by bench and checker
package bsd_ref_pkg;
	import bsd_pkg::*;
	function automatic logic tk(bsd_req_t r, logic [7:0] f);
		case (r.op)
			OP_SKIP_REG_BIT_CLEAR: return !r.reg_val[r.sel];
			OP_SKIP_IO_BIT_SET: return r.io_val[r.sel];
			OP_SKIP_IO_BIT_CLEAR: return !r.io_val[r.sel];
			OP_BRANCH_FLAG_SET: return f[r.sel];
			OP_BRANCH_FLAG_CLEAR: return !f[r.sel];
			OP_BRANCH_CARRY_CLEAR, OP_BRANCH_UNSIGNED_GE: return !f[FLG_C];
			OP_BRANCH_SIGNED_GE: return !(f[FLG_N] ^ f[FLG_V]);
			OP_BRANCH_SIGNED_LT: return f[FLG_N] ^ f[FLG_V];
			OP_BRANCH_HALFCARRY_SET: return f[FLG_H];
			OP_BRANCH_TRANSFER_BIT_SET: return f[FLG_T];
			OP_BRANCH_OVERFLOW_SET: return f[FLG_V];
			default: return 1'b0;
		endcase
	endfunction
	function automatic bsd_res_t ex(bsd_req_t r, logic [15:0] p, logic [7:0] f);
		logic w;
		w = r.next_two_words;
		if (!tk(r, f))
			return '{p + 16'h1, 1'b0, 2'd1};
		if (r.op < OP_BRANCH_FLAG_SET)
			return '{p + 16'h2 + 16'(w), 1'b1, 2'd2 + 2'(w)};
		return '{p + 16'($signed(r.offset)) + 16'h1, 1'b1, 2'd2};
	endfunction
	function automatic logic [7:0] cmpf(logic [7:0] a, logic [7:0] k, logic [7:0] f);
		logic [8:0] d;
		d = {1'b0, a} - {1'b0, k};
		f[FLG_C] = d[8];
		f[FLG_Z] = d[7:0] == 8'h00;
		f[FLG_N] = d[7];
		f[FLG_V] = (a[7] & ~k[7] & ~d[7]) | (~a[7] & k[7] & d[7]);
		f[FLG_H] = (~a[3] & k[3]) | (k[3] & d[3]) | (d[3] & ~a[3]);
		f[FLG_S] = f[FLG_N] ^ f[FLG_V];
		return f;
	endfunction
endpackage

/* File: tb/bsd_unit_asserts.sv */
// checker: answer timing and decisions of the unit
`timescale 1ns/10ps
module bsd_unit_asserts
	import bsd_pkg::*, bsd_ref_pkg::*;
(
	input wire logic        clk_sys_i,
	input wire logic        rst_i,
	input wire logic        req_valid_i,
	input wire bsd_req_t    req_i,
	input wire logic [15:0] pc_i,
	input wire logic        flags_load_i,
	input wire logic [7:0]  flags_i,
	input wire logic        res_valid_o,
	input wire bsd_res_t    res_o,
	input wire logic [7:0]  status_flags_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	a_resp_pulse: assert property (req_valid_i |=> res_valid_o)
		else $error("answer missing");
	a_no_stray: assert property (!req_valid_i |=> !res_valid_o)
		else $error("answer without request");
	a_res_all: assert property (
		req_valid_i |=> res_o == $past(ex(req_i, pc_i, status_flags_o))) else $error("bad result");
	a_fall_one: assert property (
		res_valid_o && !res_o.taken |-> res_o.pc == $past(pc_i) + 16'h1 && res_o.cycles == 2'd1)
		else $error("bad fall through");
	a_branch_two: assert property (
		res_valid_o && res_o.taken && $past(req_i.op) >= OP_BRANCH_FLAG_SET |-> res_o.cycles == 2'd2)
		else $error("bad branch cycles");
	a_cmp_flags: assert property (
		req_valid_i && req_i.op == OP_COMPARE_IMM
		|=> status_flags_o == $past(cmpf(req_i.reg_val, req_i.imm, status_flags_o)))
		else $error("bad compare flags");
	a_flags_keep: assert property (
		!(req_valid_i && req_i.op == OP_COMPARE_IMM) && !flags_load_i |=> $stable(status_flags_o))
		else $error("flags moved");
	a_flags_load: assert property (
		flags_load_i && !(req_valid_i && req_i.op == OP_COMPARE_IMM)
		|=> status_flags_o == $past(flags_i))
		else $error("flags not loaded");
	a_res_hold: assert property (!req_valid_i |=> $stable(res_o))
		else $error("result moved");
	c_skip_long: cover property (req_valid_i && req_i.op == OP_SKIP_REG_BIT_CLEAR
		&& req_i.next_two_words);
	c_cmp_then_br: cover property (req_valid_i && req_i.op == OP_COMPARE_IMM
		##1 req_valid_i && req_i.op >= OP_BRANCH_FLAG_SET);
	c_back_jump: cover property (req_valid_i && req_i.offset[6] && tk(req_i, status_flags_o));
	c_t_branch: cover property (req_valid_i && req_i.op == OP_BRANCH_TRANSFER_BIT_SET
		&& status_flags_o[FLG_T]);
endmodule
bind bsd_unit bsd_unit_asserts u_chk (.clk_sys_i, .rst_i, .req_valid_i, .req_i, .pc_i,
	.flags_load_i, .flags_i, .res_valid_o, .res_o, .status_flags_o);

/* File: tb/bsd_unit_test.sv */
// bench: directed and random requests with queued expectations
`timescale 1ns/10ps
module bsd_unit_test
	import bsd_pkg::*, bsd_ref_pkg::*;
;
	logic        clk_sys_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        req_valid_i = 1'b0;
	bsd_req_t    req_i = '0;
	logic [15:0] pc_i = 16'h0000;
	logic        flags_load_i = 1'b0;
	logic [7:0]  flags_i = 8'h00;
	logic        res_valid_o;
	bsd_res_t    res_o;
	logic [7:0]  status_flags_o;
	logic [7:0]  fl = 8'h00;
	bsd_res_t    rq[$];
	logic [7:0]  fq[$];
	bsd_req_t    r;
	int          errors = 0;
	int          n_compared = 0;
	bsd_unit u_dut (.clk_sys_i, .rst_i, .req_valid_i, .req_i, .pc_i, .flags_load_i, .flags_i,
		.res_valid_o, .res_o, .status_flags_o);
	initial forever #5 clk_sys_i = ~clk_sys_i;
	task automatic chk_res(bsd_res_t e, bsd_res_t g);
		n_compared++;
		if (g !== e)
		begin
			errors++;
			$display("[FAIL] result expected %h seen %h", e, g);
		end
	endtask
	task automatic chk_flags(logic [7:0] e, logic [7:0] g);
		n_compared++;
		if (g !== e)
		begin
			errors++;
			$display("[FAIL] flags expected %h seen %h", e, g);
		end
	endtask
	// model flags follow our own compares and loads, one edge ahead of the unit
	task automatic send(bsd_req_t q, logic [15:0] p, logic ld, logic [7:0] v);
		@(posedge clk_sys_i);
		req_valid_i <= 1'b1;
		req_i <= q;
		pc_i <= p;
		flags_load_i <= ld;
		flags_i <= v;
		rq.push_back(ex(q, p, fl));
		if (q.op == OP_COMPARE_IMM)
			fl = cmpf(q.reg_val, q.imm, fl);
		else if (ld)
			fl = v;
		fq.push_back(fl);
	endtask
	task automatic idle();
		@(posedge clk_sys_i);
		req_valid_i <= 1'b0;
		flags_load_i <= 1'b0;
	endtask
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(negedge clk_sys_i)
		if (res_valid_o === 1'b1)
		begin
			chk_res(rq.pop_front(), res_o);
			chk_flags(fq.pop_front(), status_flags_o);
		end
	initial
	begin
		repeat (5000) @(posedge clk_sys_i);
		errors++;
		summarize();
	end
	initial
	begin
		void'($urandom(32'h4C4B955A));
		repeat (20) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		r = '0;
		r.op = OP_COMPARE_IMM;
		r.reg_val = 8'h5A;
		r.imm = 8'h5A;
		send(r, 16'h0008, 1'b0, 8'h00);
		r.op = OP_BRANCH_FLAG_SET;
		r.sel = 3'h1;
		r.offset = 7'h7E;
		send(r, 16'h0010, 1'b0, 8'h00);
		r = '0;
		send(r, 16'h0020, 1'b1, 8'h40);
		r.op = OP_BRANCH_TRANSFER_BIT_SET;
		r.offset = 7'h05;
		send(r, 16'h0021, 1'b0, 8'h00);
		idle();
		$display("test walk done");
		// mostly back to back so compares feed the very next branch
		repeat (600)
		begin
			r = bsd_req_t'(39'({$urandom, $urandom}));
			r.op = bsd_op_t'(4'($urandom_range(13, 0)));
			send(r, 16'($urandom), $urandom_range(3, 0) == 0, 8'($urandom));
			if ($urandom_range(3, 0) == 0)
				idle();
		end
		repeat (4) idle();
		$display("test random done");
		summarize();
	end
endmodule
